// File: cfg_decode_pkg.sv
// Constants, field layout and carrier types for the configuration decoder.
// Assumes a single 25 MHz system clock and a synchronous active-high reset.
// ============================================================================
package cfg_decode_pkg;

  // ==========================================================================
  // Word geometry and blank value
  localparam int          WORD_W      = 14;
  localparam int          PADDR_W     = 13;
  localparam logic [13:0] BLANK_WORD  = 14'h3FFF;
  localparam logic [15:0] SUP_ADDR    = 16'h8008;
  localparam logic [15:0] MEM_ADDR    = 16'h8009;

  // Implemented-bit masks; everything else reads one
  localparam logic [13:0] SUP_IMPL    = 14'h3AEF;
  localparam logic [13:0] MEM_IMPL    = 14'h2003;

  // ==========================================================================
  // Supervisor word fields
  localparam int BIT_DEBUG_N   = 13;
  localparam int BIT_STACK     = 12;
  localparam int BIT_ONE_WAY   = 11;
  localparam int BIT_BOR_LVL   = 9;
  localparam int BOR_MODE_HI   = 7;
  localparam int BOR_MODE_LO   = 6;
  localparam int BIT_LP_BOR_N  = 5;
  localparam int WDT_HI        = 3;
  localparam int WDT_LO        = 2;
  localparam int BIT_PWRUP_N   = 1;
  localparam int BIT_RST_PIN   = 0;
  // Memory word fields
  localparam int BIT_LOW_VOLT  = 13;
  localparam int WPROT_HI      = 1;
  localparam int WPROT_LO      = 0;

  // ==========================================================================
  // Field codes
  localparam logic [1:0] BOR_ALWAYS = 2'h3;
  localparam logic [1:0] BOR_SLEEP  = 2'h2;
  localparam logic [1:0] BOR_SW     = 2'h1;
  localparam logic [1:0] WDT_ON     = 2'h3;
  localparam logic [1:0] WPROT_OFF  = 2'h3;
  localparam logic [1:0] WPROT_BOOT = 2'h2;
  localparam logic [1:0] WPROT_HALF = 2'h1;
  localparam logic [12:0] BOOT_TOP  = 13'h01FF;
  localparam logic [12:0] HALF_TOP  = 13'h0FFF;

  // ==========================================================================
  // Avalon register map (word indices as byte addresses)
  localparam logic [3:0] REG_SUP     = 4'h0;
  localparam logic [3:0] REG_MEM     = 4'h4;
  localparam logic [3:0] REG_CTRL    = 4'h8;
  localparam logic [3:0] REG_STATUS  = 4'hC;
  localparam int         CTRL_LOCK   = 0;
  localparam int         CTRL_UNLOCK = 1;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;

  typedef enum logic [1:0] {
    unlock_idle,
    unlock_half,
    unlock_open
  } unlock_e;

  // Decoded settings carried to the supervisory logic
  typedef struct packed {
    logic       debugger_en;
    logic       stack_fault_reset_en;
    logic       brownout_level_sel;
    logic       brownout_active;
    logic       lowpower_brownout_detector;
    logic       watchdog_forced;
    logic       powerup_timer;
    logic       master_reset_pin;
    logic       low_volt_prog_en;
  } decoded_s;

  // Self-write request: address and external flag
  typedef struct packed {
    logic              req;
    logic [12:0]       addr;
    logic              external;
  } nvm_write_s;

  // Whole module state
  typedef struct packed {
    logic [13:0]  supervisor_config_word;
    logic [13:0]  memory_config_word;
    decoded_s     dec;
    logic         pin_remap_lock;
    logic         lock_used;
    unlock_e      unlock;
    logic         write_grant;
    logic         write_block;
    logic         low_volt_refused;
    logic         sw_sync1;
    logic         sw_sync2;
    logic         sleep_sync1;
    logic         sleep_sync2;
    logic         wait_req;
    logic [31:0]  rdata;
    logic         rvalid_dummy;
  } state_s;

endpackage

// File: supervisor_memory_config_decode.sv
// Configuration word decoder with pin-remap lock and self-write gate.
// Words arrive from the nonvolatile array; Avalon-MM slave for software.
//
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/10ps
module supervisor_memory_config_decode
  import cfg_decode_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic [13:0] nvm_sup_word,
  input  wire logic [13:0] nvm_mem_word,
  input  wire logic        prog_write,
  input  wire logic [15:0] prog_addr,
  input  wire logic [13:0] prog_data,
  input  wire logic        prog_entered_lv,
  input  wire logic        sw_brownout_en,
  input  wire logic        sleeping,
  input  wire nvm_write_s  nvm_write,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output decoded_s         decoded,
  output logic             pin_remap_lock,
  output logic             write_grant,
  output logic             write_block,
  output logic             low_volt_refused
);

  state_s r;
  state_s next_r;
  logic   prog_sup;
  logic   prog_mem;
  logic   access;
  logic   keep_low_volt;
  logic [1:0] wprot;
  logic       hit;

  // ==========================================================================
  // Combinational next state
  always_comb begin
    next_r   = r;
    prog_sup = prog_write && (prog_addr == SUP_ADDR);
    prog_mem = prog_write && (prog_addr == MEM_ADDR);
    access   = avs_read || avs_write;
    keep_low_volt = 1'b0;
    wprot         = r.memory_config_word[WPROT_HI:WPROT_LO];
    hit      = 1'b0;

    // Asynchronous level inputs pass two flops first
    next_r.sw_sync1    = sw_brownout_en;
    next_r.sw_sync2    = r.sw_sync1;
    next_r.sleep_sync1 = sleeping;
    next_r.sleep_sync2 = r.sleep_sync1;

    // Programming writes; unimplemented bits forced to one
    if (prog_sup) begin
      next_r.supervisor_config_word = prog_data | ~SUP_IMPL;
    end
    next_r.low_volt_refused = 1'b0;
    if (prog_mem) begin
      // Low-voltage entry cannot clear its own enable bit
      keep_low_volt = prog_entered_lv && !prog_data[BIT_LOW_VOLT];
      next_r.memory_config_word = prog_data | ~MEM_IMPL;
      if (keep_low_volt) begin
        next_r.memory_config_word[BIT_LOW_VOLT] = 1'b1;
      end
      next_r.low_volt_refused = keep_low_volt;
    end

    // Brownout enable follows its mode every cycle; other decode fields latched only in reset
    next_r.dec.brownout_active = 1'b0;
    unique case (r.supervisor_config_word[BOR_MODE_HI:BOR_MODE_LO])
      BOR_ALWAYS: next_r.dec.brownout_active = 1'b1;
      BOR_SLEEP:  next_r.dec.brownout_active = !r.sleep_sync2;
      BOR_SW:     next_r.dec.brownout_active = r.sw_sync2;
      default:    next_r.dec.brownout_active = 1'b0;
    endcase

    // Self-write gate; external programming always passes
    next_r.write_grant = 1'b0;
    next_r.write_block = 1'b0;
    if (nvm_write.req) begin
      unique case (wprot)
        WPROT_OFF:  hit = 1'b0;
        WPROT_BOOT: hit = nvm_write.addr <= BOOT_TOP;
        WPROT_HALF: hit = nvm_write.addr <= HALF_TOP;
        default:  hit = 1'b1;
      endcase
      next_r.write_block = hit && !nvm_write.external;
      next_r.write_grant = !(hit && !nvm_write.external);
    end

    // Avalon slave: one wait cycle, then answer
    next_r.wait_req = 1'b1;
    if (access && r.wait_req) begin
      next_r.wait_req = 1'b0;
      next_r.rdata    = 32'h0000_0000;
      if (avs_read) begin
        unique case (avs_address)
          REG_SUP:    next_r.rdata = {18'h0, r.supervisor_config_word};
          REG_MEM:    next_r.rdata = {18'h0, r.memory_config_word};
          REG_CTRL:   next_r.rdata = {30'h0, r.unlock == unlock_open, r.pin_remap_lock};
          REG_STATUS: next_r.rdata = {31'h0, r.lock_used};
          default:    next_r.rdata = 32'h0000_0000;
        endcase
      end
      if (avs_write && avs_address == REG_CTRL) begin
        // Unlock key pair arms one lock change
        unique case (r.unlock)
          unlock_idle: if (avs_writedata[7:0] == UNLOCK_KEY1) next_r.unlock = unlock_half;
          unlock_half: next_r.unlock = (avs_writedata[7:0] == UNLOCK_KEY2) ? unlock_open : unlock_idle;
          unlock_open: begin
            next_r.unlock = unlock_idle;
            // One-way mode freezes once the lock has been set
            if (!(r.supervisor_config_word[BIT_ONE_WAY] && r.lock_used)) begin
              next_r.pin_remap_lock = avs_writedata[CTRL_LOCK];
              if (r.pin_remap_lock && !avs_writedata[CTRL_LOCK]) begin
                next_r.lock_used = 1'b0;
              end
              if (!r.pin_remap_lock && avs_writedata[CTRL_LOCK]) begin
                next_r.lock_used = 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // State register; decode fields other than brownout_active reload only while reset is held
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r                      <= '0;
      r.supervisor_config_word <= nvm_sup_word | ~SUP_IMPL;
      r.memory_config_word   <= nvm_mem_word | ~MEM_IMPL;
      r.wait_req             <= 1'b1;
      r.unlock               <= unlock_idle;
      // Settings frozen at reset so dependants see stable values
      r.dec.debugger_en      <= !nvm_sup_word[BIT_DEBUG_N];
      r.dec.stack_fault_reset_en <= nvm_sup_word[BIT_STACK];
      r.dec.brownout_level_sel   <= nvm_sup_word[BIT_BOR_LVL];
      r.dec.lowpower_brownout_detector <= !nvm_sup_word[BIT_LP_BOR_N];
      r.dec.watchdog_forced  <= nvm_sup_word[WDT_HI:WDT_LO] == WDT_ON;
      r.dec.powerup_timer    <= !nvm_sup_word[BIT_PWRUP_N];
      r.dec.master_reset_pin <= nvm_mem_word[BIT_LOW_VOLT] || nvm_sup_word[BIT_RST_PIN];
      r.dec.low_volt_prog_en <= nvm_mem_word[BIT_LOW_VOLT];
    end else if (clk_en) begin
      r <= '{supervisor_config_word: next_r.supervisor_config_word,
             memory_config_word:     next_r.memory_config_word,
             dec:                    '{r.dec.debugger_en, r.dec.stack_fault_reset_en,
                                       r.dec.brownout_level_sel, next_r.dec.brownout_active,
                                       r.dec.lowpower_brownout_detector, r.dec.watchdog_forced,
                                       r.dec.powerup_timer, r.dec.master_reset_pin,
                                       r.dec.low_volt_prog_en},
             pin_remap_lock:         next_r.pin_remap_lock,
             lock_used:              next_r.lock_used,
             unlock:                 next_r.unlock,
             write_grant:            next_r.write_grant,
             write_block:            next_r.write_block,
             low_volt_refused:       next_r.low_volt_refused,
             sw_sync1:               next_r.sw_sync1,
             sw_sync2:               next_r.sw_sync2,
             sleep_sync1:            next_r.sleep_sync1,
             sleep_sync2:            next_r.sleep_sync2,
             wait_req:               next_r.wait_req,
             rdata:                  next_r.rdata,
             rvalid_dummy:           1'b0};
    end
  end

  // ==========================================================================
  // Outputs straight from flops
  assign avs_readdata    = r.rdata;
  assign avs_waitrequest = r.wait_req;
  assign decoded         = r.dec;
  assign pin_remap_lock  = r.pin_remap_lock;
  assign write_grant     = r.write_grant;
  assign write_block     = r.write_block;
  assign low_volt_refused = r.low_volt_refused;

endmodule

// File: cfg_decode_checker.sv
// Checker for the configuration decoder: bus answer, load, lock, write gate.
// Assumes one clock, clk_sys, and rst synchronous and active high.
`timescale 1ns/10ps
module cfg_decode_checker
  import cfg_decode_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [13:0] nvm_sup_word,
  input wire logic        prog_write,
  input wire logic [15:0] prog_addr,
  input wire logic [13:0] prog_data,
  input wire logic        prog_entered_lv,
  input wire nvm_write_s  nvm_write,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire decoded_s    decoded,
  input wire logic        pin_remap_lock,
  input wire logic        write_grant,
  input wire logic        write_block,
  input wire logic        low_volt_refused
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========================================================================
  // Helper: word seen in reset, and whether a one-way lock was set
  logic [13:0] sup_q;
  logic        seen;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sup_q <= nvm_sup_word;
      seen  <= 1'b0;
    end else if (pin_remap_lock && sup_q[BIT_ONE_WAY]) begin
      seen  <= 1'b1;
    end
  end
  // ==========================================================================
  // Bus steps: taken while idle, answered next cycle, idle again after
  sequence req_s; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence ans_s; !avs_waitrequest ##1 avs_waitrequest; endsequence
  bus_answer_a: assert property (req_s |=> ans_s) else $error("bus answer late or long");
  cfg_load_a: assert property ($fell(rst) |-> decoded.debugger_en == !sup_q[13] &&
    decoded.stack_fault_reset_en == sup_q[12] && decoded.brownout_level_sel == sup_q[9] &&
    decoded.lowpower_brownout_detector == !sup_q[5] && decoded.powerup_timer == !sup_q[1])
    else $error("decoded fields wrong after reset");
  wdt_load_a: assert property ($fell(rst) |-> decoded.watchdog_forced == (sup_q[3:2] == WDT_ON))
    else $error("watchdog decode wrong");
  decode_hold_a: assert property (!$past(rst) |-> $stable(decoded.debugger_en) &&
    $stable(decoded.watchdog_forced) && $stable(decoded.low_volt_prog_en)) else $error("decode moved");
  pin_forced_a: assert property (decoded.low_volt_prog_en |-> decoded.master_reset_pin)
    else $error("reset pin not forced");
  lock_sticks_a: assert property (seen |-> pin_remap_lock) else $error("one-way lock released");
  req_answer_a: assert property (nvm_write.req |=> write_grant ^ write_block)
    else $error("self-write not answered");
  ext_grant_a: assert property (nvm_write.req && nvm_write.external |=> write_grant)
    else $error("external write blocked");
  low_volt_refuse_a: assert property (prog_write && prog_addr == MEM_ADDR && !prog_data[BIT_LOW_VOLT]
    && prog_entered_lv |=> low_volt_refused) else $error("clear of low-volt bit not refused");
endmodule

bind supervisor_memory_config_decode cfg_decode_checker cfg_decode_checker_inst (.clk_sys(clk_sys),
  .rst(rst), .nvm_sup_word(nvm_sup_word), .prog_write(prog_write), .prog_addr(prog_addr),
  .prog_data(prog_data), .prog_entered_lv(prog_entered_lv), .nvm_write(nvm_write), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .decoded(decoded),
  .pin_remap_lock(pin_remap_lock), .write_grant(write_grant), .write_block(write_block),
  .low_volt_refused(low_volt_refused));

// File: tb.sv
// Testbench: reset loads, bus readback, lock protocol, brownout and write gate.
// Assumes the bound checker; only clk_en is tied high.
`timescale 1ns/10ps
module tb
  import cfg_decode_pkg::*;
();
  logic clk_sys = 0, rst = 1, prog_write = 0, prog_entered_lv = 0, sw_brownout_en = 0, sleeping = 0;
  logic avs_read = 0, avs_write = 0, avs_waitrequest, pin_remap_lock, write_grant, write_block, low_volt_refused;
  logic [13:0] nvm_sup_word = 14'h3FFF, nvm_mem_word = 14'h3FFF, prog_data = 14'h0000;
  logic [15:0] prog_addr = 16'h0000;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  nvm_write_s  nvm_write = '0;
  decoded_s    decoded;
  int          err_count = 0, samples_checked = 0;
  logic [12:0] adr [5] = '{13'h01FF, 13'h0200, 13'h0FFF, 13'h1000, 13'h1FFF};
  always #20 clk_sys = ~clk_sys;
  supervisor_memory_config_decode supervisor_memory_config_decode_inst (.clk_sys(clk_sys), .rst(rst),
    .clk_en(1'b1), .nvm_sup_word(nvm_sup_word), .nvm_mem_word(nvm_mem_word), .prog_write(prog_write),
    .prog_addr(prog_addr), .prog_data(prog_data), .prog_entered_lv(prog_entered_lv),
    .sw_brownout_en(sw_brownout_en), .sleeping(sleeping), .nvm_write(nvm_write),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .decoded(decoded),
    .pin_remap_lock(pin_remap_lock), .write_grant(write_grant), .write_block(write_block),
    .low_volt_refused(low_volt_refused));
  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Request held until waitrequest is sampled low; no latency assumed
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    // Only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic do_reset(input logic [13:0] s, input logic [13:0] m);
    @(posedge clk_sys);
    rst <= 1'b1; nvm_sup_word <= s; nvm_mem_word <= m;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (5) @(posedge clk_sys);
  endtask
  task automatic lock_set(input logic v, input logic e);
    bus(1'b1, REG_CTRL, 32'h55); bus(1'b1, REG_CTRL, 32'hAA); bus(1'b1, REG_CTRL, {31'h0, v});
    chk(32'(pin_remap_lock), 32'(e));
  endtask
  task automatic sw_req(input logic [12:0] a, input logic x, input logic blk);
    @(posedge clk_sys);
    nvm_write <= '{1'b1, a, x};
    @(posedge clk_sys);
    nvm_write <= '0;
    // Answer launched one edge after the request; read it at the next edge
    @(posedge clk_sys);
    chk(32'({write_grant, write_block}), 32'({!blk, blk}));
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    do_reset(14'h0000, 14'h0000);
    chk(32'(decoded), 32'h114);
    bus(1'b0, REG_SUP, 32'h0); chk(q, 32'h0510);
    bus(1'b0, REG_MEM, 32'h0); chk(q, 32'h1FFC);
    bus(1'b0, 4'h2, 32'h0); chk(q, 32'h0);
    do_reset(14'h3FFF, 14'h3FFF);
    chk(32'(decoded), 32'h0EB);
    bus(1'b0, REG_SUP, 32'h0); chk(q, 32'h3FFF);
    lock_set(1'b1, 1'b1); lock_set(1'b0, 1'b1);
    bus(1'b0, REG_STATUS, 32'h0); chk(q & 32'h1, 32'h1);
    prog_entered_lv <= 1'b1;
    @(posedge clk_sys);
    prog_write <= 1'b1;
    prog_addr  <= MEM_ADDR;
    prog_data  <= 14'h0003;
    @(posedge clk_sys);
    prog_write <= 1'b0;
    @(posedge clk_sys);
    chk(32'(low_volt_refused), 32'h1);
    bus(1'b0, REG_MEM, 32'h0);
    chk(q & 32'h2000, 32'h2000);
    prog_entered_lv <= 1'b0;
    // Programming the supervisor word; unimplemented bits still read one
    @(posedge clk_sys);
    prog_write <= 1'b1;
    prog_addr  <= SUP_ADDR;
    prog_data  <= 14'h0000;
    @(posedge clk_sys);
    prog_write <= 1'b0;
    bus(1'b0, REG_SUP, 32'h0);
    chk(q, 32'h0510);
    // Repeated lock changes each need the unlock keys
    do_reset(14'h37FF, 14'h3FFF);
    lock_set(1'b1, 1'b1); lock_set(1'b0, 1'b0); lock_set(1'b1, 1'b1);
    bus(1'b1, REG_CTRL, 32'h0);
    chk(32'(pin_remap_lock), 32'h1);
    // Each brownout mode and each protection code
    for (int i = 0; i < 4; i++) begin
      sw_brownout_en <= 1'b1; sleeping <= 1'b1;
      do_reset(14'h3F3F | 14'(i << 6), 14'h3FFC | 14'(i));
      chk(32'(decoded.brownout_active), 32'(4'b1010 >> i) & 32'h1);
      sw_brownout_en <= 1'b0; sleeping <= 1'b0;
      repeat (5) @(posedge clk_sys);
      chk(32'(decoded.brownout_active), 32'(4'b1100 >> i) & 32'h1);
      foreach (adr[k]) sw_req(adr[k], 1'b0, i == 0 || (i == 2 && adr[k] <= 13'h01FF) ||
        (i == 1 && adr[k] <= 13'h0FFF));
      sw_req(13'h0000, 1'b1, 1'b0);
    end
    report_and_stop;
  end
  initial begin
    #400000;
    err_count++;
    report_and_stop;
  end
endmodule
